// File: verilog/dcc_top.sv
// Diagnostic control and cache error tag capture top level
`timescale 1ns/1ps
`default_nettype none
module dcc_top
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Processor register moves
  input  wire logic        ipr_wr,
  input  wire logic        ipr_rd,
  input  wire logic [7:0]  ipr_addr,
  input  wire logic [31:0] ipr_wdata,
  output logic      [31:0] ipr_rdata,
  output logic             ipr_rvalid,
  // Bus-interface control contents to merge on its read
  input  wire logic [31:0] biu_ctl_value,
  input  wire logic [31:0] biu_ctl_used,
  input  wire logic        biu_ctl_rd,
  output logic      [31:0] biu_ctl_rdata,
  // Write data check bits
  input  wire logic        ecc_mode,
  input  wire logic [7:0]  software_check_bit_register,
  input  wire logic [7:0]  gen_check,
  input  wire logic [63:0] wr_data,
  output logic      [7:0]  out_check,
  // Tag probe
  input  wire logic        probe,
  input  wire logic [14:0] probe_tag,
  input  wire logic        probe_match,
  input  wire logic        tag_address_parity_input,
  input  wire logic        tag_control_parity_input,
  input  wire logic        tag_shared_input,
  input  wire logic        tag_dirty_input,
  input  wire logic        tag_valid_input,
  input  wire logic        tag_perr,
  input  wire logic        tag_ctl_perr,
  input  wire logic        fill_err,
  input  wire logic        ecc_err_raw,
  input  wire logic        stat_err_clear,
  // Control outputs
  output logic             software_check_bit_enable,
  output logic      [2:0]  perfmon_access_compare_select,
  output logic      [2:0]  perfmon_hit_compare_select,
  output logic             error_report_disable,
  output logic             pack_disable,
  output logic             tod_test_mode,
  output logic             tod_increment,
  output logic             ecc_err_report,
  output logic             tag_locked
);
  //////////////////////////////////////////////////////////////////////////
  logic [31:0] diag;
  logic [31:0] tagv;
  logic        lk;
  logic        diag_wr;
  assign diag_wr = ipr_wr && ipr_addr == dcc_pkg::ADDR_DIAG;
  dcc_diag u_diag
  (
    .clk   (clk),
    .reset (reset),
    .wr    (diag_wr),
    .wdata (ipr_wdata),
    .value (diag)
  );
  dcc_tag u_tag
  (
    .clk                      (clk),
    .reset                    (reset),
    .probe                    (probe),
    .probe_tag                (probe_tag),
    .probe_match              (probe_match),
    .tag_address_parity_input (tag_address_parity_input),
    .tag_control_parity_input (tag_control_parity_input),
    .tag_shared_input         (tag_shared_input),
    .tag_dirty_input          (tag_dirty_input),
    .tag_valid_input          (tag_valid_input),
    .err_event                (tag_perr | tag_ctl_perr | fill_err),
    .stat_err_clear           (stat_err_clear),
    .value                    (tagv),
    .locked                   (lk)
  );
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    logic [31:0] rdata;
    logic        rvalid;
    logic [31:0] bdata;
    logic [7:0]  chk;
    logic        swe;
    logic [2:0]  acc;
    logic [2:0]  hit;
    logic        edis;
    logic        pdis;
    logic        ttest;
    logic        tinc;
    logic        erep;
    logic        lk;
  } dcc_st_t;
  dcc_st_t st, next_st;
  // Parity over one data half
  function automatic logic par32(input logic [31:0] d);
    par32 = ^d;
  endfunction
  always_comb
  begin
    next_st = st;
    next_st.rvalid = ipr_rd;
    // diag address reads zero; tag via register move
    next_st.rdata = 32'h0000_0000;
    if (ipr_rd && ipr_addr == dcc_pkg::ADDR_TAG)
      next_st.rdata = tagv;
    // inverted merge of diag into unused positions
    if (biu_ctl_rd)
      next_st.bdata = ~((biu_ctl_value & biu_ctl_used)
                      | (diag & ~biu_ctl_used));
    next_st.chk = gen_check;
    if (!ecc_mode)
    begin
      next_st.chk = 8'h00;
      next_st.chk[dcc_pkg::CHK_LO_PAR] = par32(wr_data[31:0]);
      next_st.chk[dcc_pkg::CHK_HI_PAR] = par32(wr_data[63:32]);
    end
    if (diag[dcc_pkg::B_SWCHK])
    begin
      next_st.chk = software_check_bit_register;
      if (!ecc_mode)
        next_st.chk = software_check_bit_register
                      & 8'h81;
    end
    next_st.swe = diag[dcc_pkg::B_SWCHK];
    next_st.acc = diag[dcc_pkg::B_ACC_HI:dcc_pkg::B_ACC_LO];
    next_st.hit = diag[dcc_pkg::B_HIT_HI:dcc_pkg::B_HIT_LO];
    next_st.edis = diag[dcc_pkg::B_ERRDIS];
    next_st.erep = ecc_err_raw && !diag[dcc_pkg::B_ERRDIS];
    next_st.pdis = diag[dcc_pkg::B_PACKDIS];
    next_st.ttest = diag[dcc_pkg::B_TODTEST];
    next_st.tinc = diag[dcc_pkg::B_TODINC] && diag[dcc_pkg::B_TODTEST];
    next_st.lk = lk;
    if (reset)
    begin
      next_st = '0;
      next_st.edis = 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end
  assign ipr_rdata                     = st.rdata;
  assign ipr_rvalid                    = st.rvalid;
  assign biu_ctl_rdata                 = st.bdata;
  assign out_check                     = st.chk;
  assign software_check_bit_enable     = st.swe;
  assign perfmon_access_compare_select = st.acc;
  assign perfmon_hit_compare_select    = st.hit;
  assign error_report_disable          = st.edis;
  assign pack_disable                  = st.pdis;
  assign tod_test_mode                 = st.ttest;
  assign tod_increment                 = st.tinc;
  assign ecc_err_report                = st.erep;
  assign tag_locked                    = st.lk;
  //////////////////////////////////////////////////////////////////////////
  // reset leaves reporting off
  err_reset_a: assert property (@(posedge clk)
    reset |=> error_report_disable && !ecc_err_report)
    else $error("report not disabled after reset");
  tod_gate_a: assert property (@(posedge clk) disable iff (reset)
    tod_increment |-> tod_test_mode)
    else $error("increment without test mode");
  diag_rd_a: assert property (@(posedge clk) disable iff (reset)
    ipr_rd && ipr_addr == dcc_pkg::ADDR_DIAG |=> ipr_rdata == 32'h0000_0000)
    else $error("diag read not zero");
  inv_read_a: assert property (@(posedge clk) disable iff (reset)
    biu_ctl_rd && !biu_ctl_used[15] |=> biu_ctl_rdata[15] == !$past(diag[15]))
    else $error("readback not inverted");
  sw_chk_a: assert property (@(posedge clk) disable iff (reset)
    diag[27] && ecc_mode |=> out_check == $past(software_check_bit_register))
    else $error("software check bits not used");
  pm_sel_a: assert property (@(posedge clk) disable iff (reset)
    diag_wr ##1 1'b1 |=> perfmon_access_compare_select == $past(ipr_wdata[26:24], 2))
    else $error("perfmon select wrong");
  pack_dis_a: assert property (@(posedge clk) disable iff (reset)
    diag_wr ##2 !$past(diag_wr) |-> pack_disable == $past(ipr_wdata[11], 2))
    else $error("pack disable wrong");
  lock_err_a: assert property (@(posedge clk) disable iff (reset)
    (tag_perr || tag_ctl_perr || fill_err) |-> ##2 tag_locked)
    else $error("tag not locked");
  tag_rd_c: cover property (@(posedge clk) ipr_rd && ipr_addr == dcc_pkg::ADDR_TAG);
  lock_c: cover property (@(posedge clk) tag_locked ##1 !tag_locked);
  tinc_c: cover property (@(posedge clk) tod_increment);
endmodule // dcc_top
`default_nettype wire

// File: verilog/dcc_pkg.sv
// Constants for the diagnostic control and cache error tag capture block
package dcc_pkg;
  localparam logic [7:0]  ADDR_DIAG    = 8'hA1;
  localparam logic [7:0]  ADDR_TAG     = 8'hA2;
  localparam logic [31:0] DIAG_MASK    = 32'h0FE0_88C0;
  localparam logic [31:0] DIAG_RESET   = 32'h0000_8000;
  localparam int          B_SWCHK      = 27;
  localparam int          B_ACC_HI     = 26;
  localparam int          B_ACC_LO     = 24;
  localparam int          B_HIT_HI     = 23;
  localparam int          B_HIT_LO     = 21;
  localparam int          B_ERRDIS     = 15;
  localparam int          B_MBZ        = 12;
  localparam int          B_PACKDIS    = 11;
  localparam int          B_TODINC     = 7;
  localparam int          B_TODTEST    = 6;
  localparam int          CHK_LO_PAR   = 0;
  localparam int          CHK_HI_PAR   = 7;
  localparam int          TAG_LO       = 17;
  localparam int          TAG_W        = 15;
endpackage

// File: verilog/dcc_diag.sv
// Diagnostic control register storage
`timescale 1ns/1ps
`default_nettype none
module dcc_diag
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Write port
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  // Stored value
  output logic      [31:0] value
);
  typedef struct packed { logic [31:0] r; } dcc_dst_t;
  dcc_dst_t st, next_st;
  always_comb
  begin
    next_st = st;
    if (wr)
      next_st.r = wdata & dcc_pkg::DIAG_MASK;
    if (reset)
      next_st.r = dcc_pkg::DIAG_RESET;
  end
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end
  assign value = st.r;
  undef_zero_a: assert property (@(posedge clk) disable iff (reset)
    (value & ~dcc_pkg::DIAG_MASK) == 32'h0000_0000)
    else $error("undefined diag bit set");
endmodule // dcc_diag
`default_nettype wire

// File: verilog/dcc_tag.sv
// Cache error tag capture register with lock
`timescale 1ns/1ps
`default_nettype none
module dcc_tag
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Probe inputs
  input  wire logic        probe,
  input  wire logic [14:0] probe_tag,
  input  wire logic        probe_match,
  input  wire logic        tag_address_parity_input,
  input  wire logic        tag_control_parity_input,
  input  wire logic        tag_shared_input,
  input  wire logic        tag_dirty_input,
  input  wire logic        tag_valid_input,
  // Error events and lock release
  input  wire logic        err_event,
  input  wire logic        stat_err_clear,
  // Captured value
  output logic      [31:0] value,
  output logic             locked
);
  typedef struct packed { logic [31:0] r; logic lk; } dcc_tst_t;
  dcc_tst_t st, next_st;
  logic [31:0] sample;
  always_comb
  begin
    sample = 32'h0000_0000;
    sample[dcc_pkg::TAG_LO +: dcc_pkg::TAG_W] = probe_tag;
    sample[16] = tag_address_parity_input;
    sample[15] = tag_control_parity_input;
    sample[14] = tag_shared_input;
    sample[13] = tag_dirty_input;
    sample[12] = tag_valid_input;
    sample[11] = probe_match;
    next_st = st;
    // load while unlocked or being released
    if ((!st.lk || stat_err_clear) && (probe || err_event))
      next_st.r = sample;
    if (stat_err_clear)
      next_st.lk = 1'b0;
    // error wins over a release in the same cycle
    if (err_event)
      next_st.lk = 1'b1;
    if (reset)
    begin
      next_st.r  = 32'h0000_0000;
      next_st.lk = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end
  assign value  = st.r;
  assign locked = st.lk;
  frozen_hold_a: assert property (@(posedge clk) disable iff (reset)
    locked && !stat_err_clear |=> $stable(value) && locked)
    else $error("locked tag changed");
endmodule // dcc_tag
`default_nettype wire

// File: test/dcc_tag_ram.sv
// Behavioural tag and tag control RAM answering cache probes
`timescale 1ns/1ps
`default_nettype none
module dcc_tag_ram
(
  // Clock
  input  wire logic        clk,
  // Fill and look-up
  input  wire logic        fill,
  input  wire logic        look,
  input  wire logic [3:0]  index,
  input  wire logic [19:0] entry,
  input  wire logic [14:0] want,
  // Probe outcome
  output logic             probe,
  output logic      [19:0] pins,
  output logic             match
);
  logic [19:0] mem [16];
  //////////////////////////////////////////////////////////////////////////
  // one outcome per look-up
  always_ff @(posedge clk)
  begin
    if (fill)
      mem[index] <= entry;
    probe <= look;
    // Released lines invert every cycle, so stale data shows again on alternate cycles
    pins  <= look ? mem[index] : ~pins;
    match <= look ? (mem[index][19:5] == want) : ~match;
  end
endmodule // dcc_tag_ram
`default_nettype wire

// File: test/dcc_top_test.sv
// Self-checking bench for the diagnostic control and tag capture block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_test;
  logic        clk, reset, ipr_wr, ipr_rd, ipr_rvalid, biu_ctl_rd;
  logic [7:0]  ipr_addr, software_check_bit_register, gen_check, out_check;
  logic [31:0] ipr_wdata, ipr_rdata, biu_ctl_value, biu_ctl_used;
  logic [31:0] biu_ctl_rdata, d, m, v, u, x;
  logic [63:0] wr_data;
  logic        ecc_mode, probe, probe_match, tag_perr, tag_ctl_perr;
  logic        fill_err, ecc_err_raw, stat_err_clear, software_check_bit_enable;
  logic [2:0]  perfmon_access_compare_select, perfmon_hit_compare_select, e;
  logic        error_report_disable, pack_disable, tod_test_mode;
  logic        tod_increment, ecc_err_report, tag_locked, fill, look;
  logic        tag_address_parity_input, tag_control_parity_input;
  logic        tag_shared_input, tag_dirty_input, tag_valid_input;
  logic [14:0] probe_tag, want;
  logic [19:0] pins, entry, ram [16];
  logic [3:0]  index, k;
  int          bad_count, tests_run;
  assign {probe_tag, tag_address_parity_input, tag_control_parity_input,
          tag_shared_input, tag_dirty_input, tag_valid_input} = pins;
  dcc_top dcc_top_i (.*);
  dcc_tag_ram dcc_tag_ram_i (.clk(clk), .fill(fill), .look(look),
    .index(index), .entry(entry), .want(want), .probe(probe), .pins(pins),
    .match(probe_match));
  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ipr_read(input logic [7:0] a, input logic [31:0] mk,
                          input logic [31:0] exp);
    int n;
    n = 0;
    ipr_addr = a;
    ipr_rd = 1'b1;
    @(negedge clk);
    ipr_rd = 1'b0;
    while (ipr_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 4)
    begin
      bad_count++;
      complete_run();
    end
    check(ipr_rdata & mk, exp);
  endtask
  // Control read returns the inverse of the design's used bits merged with diagnostic state in the rest
  task automatic biu_read(input logic [31:0] dg);
    biu_ctl_value = $urandom();
    biu_ctl_used = $urandom();
    biu_ctl_rd = 1'b1;
    @(negedge clk);
    biu_ctl_rd = 1'b0;
    check(biu_ctl_rdata, ~((biu_ctl_value & biu_ctl_used)
                         | (dg & ~biu_ctl_used)));
  endtask
  task automatic probe_at(input logic [3:0] i, input logic [14:0] w,
                          input logic [2:0] er);
    index = i;
    want = w;
    look = 1'b1;
    @(negedge clk);
    look = 1'b0;
    {tag_perr, tag_ctl_perr, fill_err} = er;
    @(negedge clk);
    {tag_perr, tag_ctl_perr, fill_err} = 3'b000;
  endtask
  function automatic logic [7:0] exp_chk(logic ec, logic sw, logic [7:0] r,
                                         logic [7:0] g, logic [63:0] w);
    if (ec)
      return sw ? r : g;
    return sw ? {r[7], 6'h00, r[0]} : {^w[63:32], 6'h00, ^w[31:0]};
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk, ipr_wr, ipr_rd, biu_ctl_rd, ecc_mode, tag_perr, tag_ctl_perr} = 0;
    {fill_err, ecc_err_raw, stat_err_clear, fill, look, index} = 0;
    {ipr_addr, ipr_wdata, biu_ctl_value, biu_ctl_used, entry, want} = 0;
    {software_check_bit_register, gen_check, wr_data} = 0;
    {bad_count, tests_run} = 0;
    reset = 1'b1;
    void'($urandom(74273));
    repeat (20) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(error_report_disable, 32'h0000_0001);
    biu_read(32'h0000_8000);
    for (int i = 0; i < 16; i++)
    begin
      ram[i] = $urandom();
      {fill, index, entry} = {1'b1, 4'(i), ram[i]};
      @(negedge clk);
    end
    fill = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 32'h0000_0040 : (i == 1) ? 32'h0000_00C0 :
          (i == 2) ? 32'hFFFF_FFFF : $urandom();
      d[12] = 1'b0;
      {ipr_addr, ipr_wdata, ipr_wr} = {8'hA1, d, 1'b1};
      @(negedge clk);
      ipr_wr = 1'b0;
      m = d & dcc_pkg::DIAG_MASK;
      {ecc_mode, ecc_err_raw, software_check_bit_register} = $urandom();
      gen_check = $urandom();
      wr_data = {$urandom(), $urandom()};
      repeat (2) @(negedge clk);
      v = {software_check_bit_enable, perfmon_access_compare_select,
           perfmon_hit_compare_select, error_report_disable, pack_disable,
           tod_test_mode, tod_increment, ecc_err_report};
      u = {m[27], m[26:24], m[23:21], m[15], m[11], m[6], m[7] & m[6],
           ecc_err_raw & ~m[15]};
      check(v, u);
      check(out_check, exp_chk(ecc_mode, m[27], software_check_bit_register,
                               gen_check, wr_data));
      biu_read(m);
      ipr_read(8'hA1 + 8'(i % 3 * 2), 32'hFFFF_FFFF, 32'h0);
    end
    for (int i = 0; i < 12; i++)
    begin
      k = $urandom();
      want = (i % 2 == 1) ? ram[k][19:5] : 15'($urandom());
      e = (i % 4 == 3) ? 3'(3'b100 >> (i / 4)) : 3'b000;
      x = {ram[k], ram[k][19:5] == want, 11'h000};
      probe_at(k, want, e);
      if (e == 3'b000)
        ipr_read(8'hA2, 32'hFFFE_0000, x & 32'hFFFE_0000);
      else
      begin
        @(negedge clk);
        check(tag_locked, 32'h0000_0001);
        probe_at(k ^ 4'h1, ~want, 3'b000);
        ipr_read(8'hA2, 32'hFFFF_F800, x);
        stat_err_clear = 1'b1;
        @(negedge clk);
        stat_err_clear = 1'b0;
        repeat (2) @(negedge clk);
        check(tag_locked, 32'h0000_0000);
      end
    end
    complete_run();
  end
endmodule // dcc_top_test
`default_nettype wire
